/* File: common/issr_pkg.sv */
package issr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_THR_LOW_UPPER = 8'h09;
    localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h0A;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h0B;
    localparam logic [7:0] ADDR_MEAS_FLAGS = 8'h20;
    localparam logic [7:0] ADDR_PROX_LOW = 8'h21;
    localparam logic [7:0] ADDR_PROX_HIGH = 8'h22;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FLAG_OSC_BIT = 7;
    localparam int FLAG_READY_BIT = 6;
    localparam int FLAG_WAKE_BIT = 5;
    localparam int FLAG_CMP_BIT = 4;
    localparam int PIN_MODE_MSB = 2;
    localparam int POWER_STATE_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_THR_LOW = 16'h0000;
    localparam logic [2:0] RST_PIN_MODE = 3'h0;
    localparam logic RST_POWER_STATE = 1'b0;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic RST_STATUS_BIT = 1'b1;

    // ------------------------------------------------------------
    // interrupt pin mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_READY = 3'h4;
    localparam logic [2:0] MODE_COMPARE = 3'h2;
    localparam logic [2:0] MODE_WAKE = 3'h1;
    localparam logic [2:0] MODE_OFF = 3'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wr;
        logic rd;
    } issr_reg_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] prox;
        logic [23:0] freq;
    } issr_conv_s;

endpackage : issr_pkg

/* File: rtl/issr_result_latch.sv */
`timescale 1ns/1ns
module issr_result_latch (
    input wire logic clock,
    input wire logic rst_n,
    input wire issr_pkg::issr_conv_s conv,
    input wire logic latchReq,
    output issr_pkg::issr_conv_s pending,
    output issr_pkg::issr_conv_s held,
    output logic newData
);
    import issr_pkg::*;

    // ------------------------------------------------------------
    // newest conversion, waiting for a low-byte read
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending <= '0;
        end else if (conv.valid) begin
            pending <= conv;
        end
    end

    // ------------------------------------------------------------
    // host-visible copy, refreshed only at low-byte read
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
        end else if (latchReq) begin
            held <= pending;
        end
    end

    // new conversion wins over the read that clears the flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            newData <= 1'b0;
        end else if (conv.valid) begin
            newData <= 1'b1;
        end else if (latchReq) begin
            newData <= 1'b0;
        end
    end

    AST_LATCH_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !latchReq |=> $stable(held))
        else $error("held result changed without a low-byte read");

    AST_LATCH_TAKE: assert property (@(posedge clock) disable iff (!rst_n)
        latchReq |=> held == $past(pending))
        else $error("low-byte read did not refresh held result");

    AST_NEW_DATA_SET: assert property (@(posedge clock) disable iff (!rst_n)
        conv.valid |=> newData ##0 pending.prox == $past(conv.prox))
        else $error("conversion did not mark new data");

endmodule : issr_result_latch

/* File: rtl/issr_threshold_cmp.sv */
`timescale 1ns/1ns
module issr_threshold_cmp (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic convValid,
    input wire logic [15:0] prox,
    input wire logic [15:0] thrLow,
    input wire logic [15:0] thrHigh,
    input wire logic wakeEnable,
    output logic cmpStatus,
    output logic wakeStatus
);
    import issr_pkg::*;

    logic aboveHigh;
    logic belowLow;

    assign aboveHigh = prox > thrHigh;
    assign belowLow = prox < thrLow;

    // ------------------------------------------------------------
    // comparator with hysteresis between the thresholds
    // ------------------------------------------------------------
    // misordered thresholds: the high side takes priority
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmpStatus <= RST_STATUS_BIT;
        end else if (convValid) begin
            if (aboveHigh) begin
                cmpStatus <= 1'b0;
            end else if (belowLow) begin
                cmpStatus <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // wake-up: sticky while enabled, released when disabled
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wakeStatus <= RST_STATUS_BIT;
        end else if (!wakeEnable) begin
            wakeStatus <= 1'b1;
        end else if (convValid && aboveHigh) begin
            wakeStatus <= 1'b0;
        end
    end

    AST_CMP_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
        convValid && aboveHigh |=> !cmpStatus)
        else $error("comparator not low above high threshold");

    AST_CMP_LOW: assert property (@(posedge clock) disable iff (!rst_n)
        convValid && belowLow && !aboveHigh |=> cmpStatus)
        else $error("comparator not high below low threshold");

    AST_CMP_ONCE: assert property (@(posedge clock) disable iff (!rst_n)
        !convValid |=> $stable(cmpStatus))
        else $error("comparator moved without a conversion");

    AST_WAKE_FIRE: assert property (@(posedge clock) disable iff (!rst_n)
        wakeEnable && convValid && aboveHigh ##1 wakeEnable [*2] |-> !wakeStatus)
        else $error("wake-up not held after trigger");

    AST_WAKE_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        !wakeEnable |=> wakeStatus)
        else $error("wake-up flag low while disabled");

endmodule : issr_threshold_cmp

/* File: rtl/issr_status_regs.sv */
`timescale 1ns/1ns
// How it works
// - upper-byte write commits buffer plus new byte
// - upper-byte read returns committed threshold bits 15:8
// - mode field picks pin: ready, compare, wake, off
// - power bit: clear standby, set converts
// - flag bit 7 reports oscillator stopped
// - ready bit reads zero while result unread
// - wake bit zero when triggered, one disabled
// - compare bit zero above high, one below low
// - result read as low byte then high byte
// - result copies refresh only at low-byte read
module issr_status_regs (
    input wire logic clock,
    input wire logic rst_n,
    input wire issr_pkg::issr_reg_req_s regReq,
    output logic [7:0] regRdData,
    input wire logic [7:0] lowBufByte,
    input wire logic [15:0] thrHigh,
    input wire logic oscillatorFaultFlag,
    input wire issr_pkg::issr_conv_s convIn,
    output logic [15:0] thrLowCommitted,
    output logic powerStateSelect,
    output logic [23:0] latchedFreq,
    output logic interruptOutputPinN
);
    import issr_pkg::*;

    logic [2:0] pinMode;
    logic oscFlag;
    logic resultAvailableIndicatorN;
    logic cmpStatus;
    logic wakeStatus;
    logic newData;
    logic latchReq;
    logic wakeEnable;
    logic [7:0] flagsNow;
    logic next_pinN;
    issr_conv_s convAccept;
    issr_conv_s pending;
    issr_conv_s held;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic isWrite(input issr_reg_req_s req, input logic [7:0] addr);
        isWrite = req.wr && (req.addr == addr);
    endfunction : isWrite

    function automatic logic isRead(input issr_reg_req_s req, input logic [7:0] addr);
        isRead = req.rd && (req.addr == addr);
    endfunction : isRead

    function automatic logic [7:0] readMux(
        input logic [7:0] addr,
        input logic [15:0] thrLowValue,
        input logic [2:0] mode,
        input logic power,
        input logic [7:0] flags,
        input logic [15:0] proxNew,
        input logic [15:0] proxHeld
    );
        logic [7:0] value;
        value = 8'h00;
        if (addr == ADDR_THR_LOW_UPPER) begin
            value = thrLowValue[15:8];
        end else if (addr == ADDR_PIN_FUNCTION) begin
            value = {5'h00, mode};
        end else if (addr == ADDR_POWER_CONTROL) begin
            value = {7'h00, power};
        end else if (addr == ADDR_MEAS_FLAGS) begin
            value = flags;
        end else if (addr == ADDR_PROX_LOW) begin
            // the read itself refreshes the copy, so it sees the newest result
            value = proxNew[7:0];
        end else if (addr == ADDR_PROX_HIGH) begin
            value = proxHeld[15:8];
        end
        readMux = value;
    endfunction : readMux

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // the lower byte comes from the buffer register, which the host
    // must have written first; nothing here can check that ordering
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            thrLowCommitted <= RST_THR_LOW;
        end else if (isWrite(regReq, ADDR_THR_LOW_UPPER)) begin
            thrLowCommitted <= {regReq.wrData, lowBufByte};
        end
    end

    // reserved codes are stored but drive the pin as disabled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMode <= RST_PIN_MODE;
        end else if (isWrite(regReq, ADDR_PIN_FUNCTION)) begin
            pinMode <= regReq.wrData[PIN_MODE_MSB:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            powerStateSelect <= RST_POWER_STATE;
        end else if (isWrite(regReq, ADDR_POWER_CONTROL)) begin
            powerStateSelect <= regReq.wrData[POWER_STATE_BIT];
        end
    end

    // ------------------------------------------------------------
    // conversion intake and result latch
    // ------------------------------------------------------------
    // standby drops conversions, so the pending result and the comparator bit freeze
    always_comb begin
        convAccept = convIn;
        convAccept.valid = convIn.valid && powerStateSelect;
    end

    assign latchReq = isRead(regReq, ADDR_PROX_LOW);
    assign wakeEnable = pinMode == MODE_WAKE;

    issr_result_latch resultLatch (
        .clock(clock),
        .rst_n(rst_n),
        .conv(convAccept),
        .latchReq(latchReq),
        .pending(pending),
        .held(held),
        .newData(newData)
    );

    issr_threshold_cmp thresholdCmp (
        .clock(clock),
        .rst_n(rst_n),
        .convValid(convAccept.valid),
        .prox(convAccept.prox),
        .thrLow(thrLowCommitted),
        .thrHigh(thrHigh),
        .wakeEnable(wakeEnable),
        .cmpStatus(cmpStatus),
        .wakeStatus(wakeStatus)
    );

    assign latchedFreq = held.freq;

    // ------------------------------------------------------------
    // measurement flags
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            oscFlag <= 1'b0;
        end else begin
            oscFlag <= oscillatorFaultFlag;
        end
    end

    assign resultAvailableIndicatorN = ~newData;

    always_comb begin
        flagsNow = 8'h00;
        flagsNow[FLAG_OSC_BIT] = oscFlag;
        flagsNow[FLAG_READY_BIT] = resultAvailableIndicatorN;
        flagsNow[FLAG_WAKE_BIT] = wakeStatus;
        flagsNow[FLAG_CMP_BIT] = cmpStatus;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= RST_READ_DATA;
        end else if (regReq.rd) begin
            regRdData <= readMux(regReq.addr, thrLowCommitted, pinMode, powerStateSelect,
                flagsNow, pending.prox, held.prox);
        end
    end

    // ------------------------------------------------------------
    // interrupt pin, active low, idle high
    // ------------------------------------------------------------
    always_comb begin
        case (pinMode)
            MODE_READY: next_pinN = resultAvailableIndicatorN;
            MODE_COMPARE: next_pinN = cmpStatus;
            MODE_WAKE: next_pinN = wakeStatus;
            default: next_pinN = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interruptOutputPinN <= 1'b1;
        end else begin
            interruptOutputPinN <= next_pinN;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_THR_COMMIT: assert property (@(posedge clock) disable iff (!rst_n)
        isWrite(regReq, ADDR_THR_LOW_UPPER) |=> thrLowCommitted == {$past(regReq.wrData), $past(lowBufByte)})
        else $error("low threshold not committed from buffer and upper byte");

    AST_THR_READ: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_THR_LOW_UPPER) && !regReq.wr |=> regRdData == thrLowCommitted[15:8])
        else $error("upper-byte read mismatches committed threshold");

    AST_PIN_READY: assert property (@(posedge clock) disable iff (!rst_n)
        pinMode == MODE_READY |=> interruptOutputPinN == $past(resultAvailableIndicatorN))
        else $error("pin does not follow ready indication");

    AST_PIN_COMPARE: assert property (@(posedge clock) disable iff (!rst_n)
        pinMode == MODE_COMPARE |=> interruptOutputPinN == $past(cmpStatus))
        else $error("pin does not follow comparator");

    AST_PIN_OFF: assert property (@(posedge clock) disable iff (!rst_n)
        pinMode == MODE_OFF |=> interruptOutputPinN)
        else $error("pin active while all modes disabled");

    AST_STANDBY_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
        !powerStateSelect && !latchReq |=> $stable(newData) && $stable(pending))
        else $error("conversion taken in standby");

    AST_OSC_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_MEAS_FLAGS) |=> regRdData[FLAG_OSC_BIT] == $past(oscillatorFaultFlag, 2))
        else $error("oscillator flag read wrong");

    AST_READY_READ: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_MEAS_FLAGS) |=> regRdData[FLAG_READY_BIT] == $past(~newData))
        else $error("ready bit does not show unread result");

    // high byte read right after the low byte, or after one idle cycle
    AST_PROX_BYTES: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_PROX_LOW) ##1
            (isRead(regReq, ADDR_PROX_HIGH) or (!regReq.rd ##1 isRead(regReq, ADDR_PROX_HIGH))) |=>
            {regRdData, $past(regRdData)} == $past(held.prox))
        else $error("result bytes do not pair into one conversion");

    AST_DONT_CARE: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_MEAS_FLAGS) |=> regRdData[3:0] == 4'h0)
        else $error("flag bits 3:0 not zero");

    AST_PIN_WAKE: assert property (@(posedge clock) disable iff (!rst_n)
        pinMode == MODE_WAKE |=> interruptOutputPinN == $past(wakeStatus))
        else $error("pin does not follow wake-up flag");

    AST_POWER_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        isWrite(regReq, ADDR_POWER_CONTROL) |=> powerStateSelect == $past(regReq.wrData[POWER_STATE_BIT]))
        else $error("power bit not taken from write");

    AST_PROX_LOW_READ: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_PROX_LOW) |=> regRdData == $past(pending.prox[7:0]))
        else $error("low result byte not from newest conversion");

    AST_STATUS_READ: assert property (@(posedge clock) disable iff (!rst_n)
        isRead(regReq, ADDR_MEAS_FLAGS) |=>
            {regRdData[FLAG_WAKE_BIT], regRdData[FLAG_CMP_BIT]} == $past({wakeStatus, cmpStatus}))
        else $error("wake or comparator bit read wrong");

endmodule : issr_status_regs

/* File: verif/issr_host_model.sv */
`timescale 1ns/1ns
module issr_host_model (
    input wire logic clock,
    input wire logic [7:0] regRdData,
    output issr_pkg::issr_reg_req_s regReq,
    output logic [7:0] lowBufByte
);
    import issr_pkg::*;

    initial begin
        regReq = '0;
        lowBufByte = 8'h00;
    end

    // ----------------
    // bus cycles
    // ----------------
    // idle address flips so a stale decode cannot look like a match
    task automatic endCycle();
        regReq.wr <= 1'b0;
        regReq.rd <= 1'b0;
        regReq.addr <= ~regReq.addr;
        regReq.wrData <= ~regReq.wrData;
    endtask : endCycle

    task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        regReq <= '{addr, data, 1'b1, 1'b0};
        @(posedge clock);
        endCycle();
        #1;
    endtask : writeReg

    task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        regReq <= '{addr, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        endCycle();
        #1;
        data = regRdData;
    endtask : readReg

    // buffer byte first, upper byte second
    task automatic setLowThreshold(input logic [15:0] value);
        @(posedge clock);
        lowBufByte <= value[7:0];
        writeReg(ADDR_THR_LOW_UPPER, value[15:8]);
    endtask : setLowThreshold

endmodule : issr_host_model

/* File: verif/test_inductive_sensor_status_regs.sv */
`timescale 1ns/1ns
module test_inductive_sensor_status_regs;
    import issr_pkg::*;

    localparam int CYCLE_LIMIT = 4000;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] thrHigh = 16'h8000;
    logic oscillatorFaultFlag = 1'b0;
    issr_conv_s convIn = '0;
    issr_reg_req_s regReq;
    logic [7:0] regRdData;
    logic [7:0] lowBufByte;
    logic [15:0] thrLowCommitted;
    logic powerStateSelect;
    logic [23:0] latchedFreq;
    logic interruptOutputPinN;
    int error_cnt = 0;
    int n_checks = 0;
    int cycleCnt = 0;
    logic [2:0] modeTab [5] = '{MODE_READY, MODE_COMPARE, MODE_COMPARE, MODE_WAKE, MODE_OFF};
    logic [15:0] proxTab [5] = '{16'h9123, 16'h9123, 16'h1111, 16'h9123, 16'h9123};
    logic pinTab [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    // above the high threshold wins over below the low one, so 9123 reads comparator 0
    logic [7:0] flagTab [5] = '{8'h20, 8'h20, 8'h30, 8'h00, 8'h20};

    always #25 clock = ~clock;

    issr_host_model u_host (
        .clock(clock),
        .regRdData(regRdData),
        .regReq(regReq),
        .lowBufByte(lowBufByte)
    );

    issr_status_regs u_dut (
        .clock(clock),
        .rst_n(rst_n),
        .regReq(regReq),
        .regRdData(regRdData),
        .lowBufByte(lowBufByte),
        .thrHigh(thrHigh),
        .oscillatorFaultFlag(oscillatorFaultFlag),
        .convIn(convIn),
        .thrLowCommitted(thrLowCommitted),
        .powerStateSelect(powerStateSelect),
        .latchedFreq(latchedFreq),
        .interruptOutputPinN(interruptOutputPinN)
    );

    // ----------------
    // helpers
    // ----------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge clock) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == CYCLE_LIMIT) begin
            $display("[FAIL] run length expected below %0d seen %0d", CYCLE_LIMIT, cycleCnt);
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [23:0] expVal, input logic [23:0] seen);
        n_checks++;
        if (seen !== expVal) begin
            $display("[FAIL] %s expected %0h seen %0h", what, expVal, seen);
            error_cnt++;
        end
    endtask : chk

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] expVal, input string what);
        logic [7:0] got;
        u_host.readReg(addr, got);
        chk(what, {16'h0000, expVal}, {16'h0000, got});
    endtask : rdChk

    // valid pulse, then two more edges so flags and pin have settled
    task automatic convert(input logic [15:0] prox, input logic [23:0] freq);
        @(posedge clock);
        convIn <= '{1'b1, prox, freq};
        @(posedge clock);
        convIn <= '{1'b0, ~prox, ~freq};
        repeat (2) @(posedge clock);
        #1;
    endtask : convert

    task automatic endTest(input string name);
        $display("test %s done, mismatches so far %0d", name, error_cnt);
    endtask : endTest

    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (8) @(posedge clock);
        #1;
        chk("pin in reset", 24'h1, {23'h0, interruptOutputPinN});
        chk("power in reset", 24'h0, {23'h0, powerStateSelect});
        chk("low threshold in reset", 24'h0, {8'h00, thrLowCommitted});
        chk("freq in reset", 24'h0, latchedFreq);
        @(posedge clock);
        rst_n <= 1'b1;
        rdChk(ADDR_THR_LOW_UPPER, 8'h00, "thr upper reset");
        rdChk(ADDR_PIN_FUNCTION, 8'h00, "pin function reset");
        rdChk(ADDR_POWER_CONTROL, 8'h00, "power reset");
        rdChk(ADDR_MEAS_FLAGS, 8'h70, "flags reset");
        endTest("reset");

        convert(16'h9123, 24'h456789);
        rdChk(ADDR_MEAS_FLAGS, 8'h70, "flags standby");
        u_host.setLowThreshold(16'hABCD);
        chk("low threshold", 24'h00ABCD, {8'h00, thrLowCommitted});
        rdChk(ADDR_THR_LOW_UPPER, 8'hAB, "thr upper");
        rdChk(8'h08, 8'h00, "unmapped 08");
        rdChk(8'h23, 8'h00, "unmapped 23");
        u_host.writeReg(ADDR_POWER_CONTROL, 8'h01);
        chk("power active", 24'h1, {23'h0, powerStateSelect});
        rdChk(ADDR_POWER_CONTROL, 8'h01, "power readback");
        endTest("threshold and power");

        convert(16'h9123, 24'h456789);
        rdChk(ADDR_MEAS_FLAGS, 8'h20, "flags new data");
        rdChk(ADDR_PROX_LOW, 8'h23, "prox low");
        chk("latched freq", 24'h456789, latchedFreq);
        rdChk(ADDR_PROX_HIGH, 8'h91, "prox high");
        rdChk(ADDR_MEAS_FLAGS, 8'h60, "flags consumed");
        convert(16'h1111, 24'h0A0B0C);
        rdChk(ADDR_PROX_HIGH, 8'h91, "prox high stale");
        chk("freq stale", 24'h456789, latchedFreq);
        rdChk(ADDR_PROX_LOW, 8'h11, "prox low fresh");
        rdChk(ADDR_PROX_HIGH, 8'h11, "prox high fresh");
        chk("freq fresh", 24'h0A0B0C, latchedFreq);
        endTest("proximity");

        for (int i = 0; i < 5; i++) begin
            u_host.writeReg(ADDR_PIN_FUNCTION, {5'h00, modeTab[i]});
            rdChk(ADDR_PIN_FUNCTION, {5'h00, modeTab[i]}, "mode readback");
            convert(proxTab[i], {8'h00, proxTab[i]});
            chk("pin", {23'h0, pinTab[i]}, {23'h0, interruptOutputPinN});
            rdChk(ADDR_MEAS_FLAGS, flagTab[i], "flags mode");
        end
        endTest("pin modes");

        @(posedge clock);
        oscillatorFaultFlag <= 1'b1;
        repeat (3) @(posedge clock);
        rdChk(ADDR_MEAS_FLAGS, 8'hA0, "flags osc fault");
        endTest("oscillator");
        give_verdict();
    end

endmodule : test_inductive_sensor_status_regs
